/* core/tcc_pkg.sv */
// Shared constants, register map and carrier types of the touch channel control block
package tcc_pkg;

  localparam int NUM_IN = 6;
  localparam int CAL_W  = 10;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CAL_REQ = 8'h26;
  localparam logic [7:0] ADDR_IRQ_EN  = 8'h27;
  localparam logic [7:0] ADDR_RPT_EN  = 8'h28;
  localparam logic [5:0] RST_CAL_REQ  = 6'h00;
  localparam logic [5:0] RST_IRQ_EN   = 6'h3f;
  localparam logic [5:0] RST_RPT_EN   = 6'h3f;
  localparam logic [1:0] UNUSED_BITS  = 2'h0;
  localparam logic [5:0] CH_ONE       = 6'h01;
  localparam logic [5:0] CH_NONE      = 6'h00;
  localparam logic [2:0] IDX_FIRST    = 3'h0;
  localparam logic [2:0] IDX_LAST     = 3'h5;
  localparam logic [2:0] IDX_ONE      = 3'h1;

  // ------------------------------------------------------------
  // Calibration value limits
  // ------------------------------------------------------------
  localparam logic [CAL_W-1:0] CAL_MAX = 10'h3ff;
  localparam logic [CAL_W-1:0] CAL_MIN = 10'h000;
  localparam logic [CAL_W-1:0] CAL_RST = 10'h000;

  // ------------------------------------------------------------
  // Timing: one step of press and repeat timing is 35 ms
  // ------------------------------------------------------------
  localparam int CLK_HZ      = 40_000_000;
  localparam int MS_PER_S    = 1000;
  localparam int STEP_MS     = 35;
  localparam int STEP_CYCLES = CLK_HZ / MS_PER_S * STEP_MS;
  localparam int STEP_CNT_W  = 21;
  localparam int HOLD_CNT_W  = 5;
  localparam logic [HOLD_CNT_W-1:0] HOLD_CNT_ZERO = 5'h00;
  localparam logic [HOLD_CNT_W-1:0] HOLD_CNT_ONE  = 5'h01;
  localparam logic [HOLD_CNT_W-1:0] HOLD_CNT_MAX  = 5'h1f;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_SCAN = 2'b01,
    CAL_WAIT = 2'b10
  } tcc_cal_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } tcc_reg_req_t;

  typedef struct packed {
    logic             done;
    logic [CAL_W-1:0] value;
  } tcc_cal_rsp_t;

endpackage

/* core/tcc_step_div.sv */
// Divider that makes the one-cycle 35 ms step enable
`timescale 1ns/1ps
module tcc_step_div #(
  parameter int unsigned STEP_CYCLES = tcc_pkg::STEP_CYCLES
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  output logic      o_tick
);

  logic [tcc_pkg::STEP_CNT_W-1:0] cnt_r;
  logic                           tick_r;
  logic                           wrap;

  assign wrap   = (cnt_r == tcc_pkg::STEP_CNT_W'(STEP_CYCLES - 1));
  assign o_tick = tick_r;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= wrap;
      if (wrap) begin
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + tcc_pkg::STEP_CNT_W'(1);
      end
    end
  end

endmodule

/* core/tcc_chan_evt.sv */
// Per-input touch, release and auto-repeat event generator with press-and-hold detection on o_hold
`timescale 1ns/1ps
module tcc_chan_evt (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_tick,
  input  wire logic       i_touch,
  input  wire logic       i_rpt_en,
  input  wire logic       i_rel_en,
  input  wire logic [3:0] i_min_press,
  input  wire logic [3:0] i_interval,
  output logic            o_event,
  output logic            o_hold
);

  logic                           touch_d_r;
  logic                           hold_r;
  logic                           event_r;
  logic [tcc_pkg::HOLD_CNT_W-1:0] cnt_r;
  logic                           rise;
  logic                           fall;
  logic                           hold_hit;
  logic                           rpt_hit;

  assign rise     = i_touch & ~touch_d_r;
  assign fall     = ~i_touch & touch_d_r;
  // Longer than the setting: the hold is declared on the tick after setting+1 full steps
  assign hold_hit = i_tick & ~hold_r & i_rpt_en & (cnt_r == ({1'b0, i_min_press} + tcc_pkg::HOLD_CNT_ONE));
  assign rpt_hit  = i_tick & hold_r & i_rpt_en & i_touch & ~rise
                  & (cnt_r == {1'b0, i_interval});
  assign o_event  = event_r;
  assign o_hold   = hold_r;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      touch_d_r <= 1'b0;
    end else begin
      touch_d_r <= i_touch;
    end
  end

  // ------------------------------------------------------------
  // Hold and repeat step counting
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hold_r <= 1'b0;
      cnt_r  <= tcc_pkg::HOLD_CNT_ZERO;
    end else if (rise || !i_touch) begin
      hold_r <= 1'b0;
      cnt_r  <= tcc_pkg::HOLD_CNT_ZERO;
    end else if (hold_hit || rpt_hit) begin
      hold_r <= 1'b1;
      cnt_r  <= tcc_pkg::HOLD_CNT_ZERO;
    end else if (i_tick && cnt_r != tcc_pkg::HOLD_CNT_MAX) begin
      cnt_r <= cnt_r + tcc_pkg::HOLD_CNT_ONE;
    end
  end

  // Touch always, release when enabled, repeats only while held with repeat on
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      event_r <= 1'b0;
    end else begin
      event_r <= rise | (fall & i_rel_en) | rpt_hit;
    end
  end

  property p_touch_event;
    @(posedge i_clk) disable iff (!i_rst_n)
    rise |=> o_event;
  endproperty
  a_touch_event: assert property (p_touch_event) else $error("touch gave no event");

  property p_no_repeat_off;
    @(posedge i_clk) disable iff (!i_rst_n)
    (!i_rpt_en && i_touch && touch_d_r) |=> !o_event;
  endproperty
  a_no_repeat_off: assert property (p_no_repeat_off) else $error("repeat event with repeat off");

endmodule

/* core/tcc_top.sv */
// Calibration request, touch interrupt gating and auto-repeat control for six sense inputs
`timescale 1ns/1ps
module tcc_top #(
  parameter int unsigned STEP_CYCLES = tcc_pkg::STEP_CYCLES
) (
  input  wire logic                                     i_clk,
  input  wire logic                                     i_rst_n,
  input  wire tcc_pkg::tcc_reg_req_t                    i_reg,
  output logic [7:0]                                    o_reg_rdata,
  input  wire logic [tcc_pkg::NUM_IN-1:0]               i_touch,
  input  wire logic [tcc_pkg::NUM_IN-1:0]               i_noise,
  input  wire logic [tcc_pkg::NUM_IN-1:0]               i_newly_enabled,
  input  wire logic                                     i_release_irq_enable,
  input  wire logic [3:0]                               i_min_press,
  input  wire logic [3:0]                               i_repeat_interval,
  output logic                                          o_cal_start,
  output logic [2:0]                                    o_cal_chan,
  input  wire tcc_pkg::tcc_cal_rsp_t                    i_cal_rsp,
  output logic [tcc_pkg::NUM_IN-1:0][tcc_pkg::CAL_W-1:0] o_channel_cal_value,
  output logic                                          o_analog_cal_failure_flag,
  input  wire logic                                     i_cal_fail_clr,
  output logic                                          o_alert_n,
  input  wire logic                                     i_alert_clr,
  output logic [tcc_pkg::NUM_IN-1:0]                    o_chan_event
);

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic [tcc_pkg::NUM_IN-1:0]              cal_req_r;
  logic [tcc_pkg::NUM_IN-1:0]              cal_req_nxt;
  logic [tcc_pkg::NUM_IN-1:0]              irq_en_r;
  logic [tcc_pkg::NUM_IN-1:0]              rpt_en_r;
  logic [tcc_pkg::NUM_IN-1:0]              fail_r;
  logic [tcc_pkg::NUM_IN-1:0][tcc_pkg::CAL_W-1:0] cal_val_r;
  logic [7:0]                              rdata_r;
  logic                                    analog_cal_failure_flag_r;
  logic                                    alert_r;
  logic                                    start_r;
  tcc_pkg::tcc_cal_state_t                 state_r;
  logic [2:0]                              idx_r;

  logic                                    wr_cal;
  logic                                    wr_irq;
  logic                                    wr_rpt;
  logic [tcc_pkg::NUM_IN-1:0]              pending;
  logic [tcc_pkg::NUM_IN-1:0]              idx_mask;
  logic                                    done_w;
  logic                                    cal_ok;
  logic [tcc_pkg::NUM_IN-1:0]              clr_ok;
  logic [tcc_pkg::NUM_IN-1:0]              new_req;
  logic [tcc_pkg::NUM_IN-1:0]              evt;
  logic [tcc_pkg::NUM_IN-1:0]              gated_evt;
  logic                                    step_tick;

  assign wr_cal   = i_reg.wr && (i_reg.addr == tcc_pkg::ADDR_CAL_REQ);
  assign wr_irq   = i_reg.wr && (i_reg.addr == tcc_pkg::ADDR_IRQ_EN);
  assign wr_rpt   = i_reg.wr && (i_reg.addr == tcc_pkg::ADDR_RPT_EN);
  assign idx_mask = tcc_pkg::CH_ONE << idx_r;
  assign pending  = cal_req_r & ~fail_r;
  assign done_w   = (state_r == tcc_pkg::CAL_WAIT) && i_cal_rsp.done;
  // A noisy input or a value pinned at a rail is not a good calibration
  assign cal_ok   = done_w && !i_noise[idx_r] && (i_cal_rsp.value != tcc_pkg::CAL_MAX)
                  && (i_cal_rsp.value != tcc_pkg::CAL_MIN);
  assign clr_ok   = cal_ok ? idx_mask : tcc_pkg::CH_NONE;
  assign new_req  = (wr_cal ? i_reg.wdata[tcc_pkg::NUM_IN-1:0] : tcc_pkg::CH_NONE) | i_newly_enabled;

  // ------------------------------------------------------------
  // Calibration request register
  // ------------------------------------------------------------
  // Host write replaces the bits, hardware newly-enabled sets win over everything
  always_comb begin
    if (wr_cal) begin
      cal_req_nxt = i_reg.wdata[tcc_pkg::NUM_IN-1:0];
    end else begin
      cal_req_nxt = cal_req_r & ~clr_ok;
    end
    cal_req_nxt = cal_req_nxt | i_newly_enabled;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cal_req_r <= tcc_pkg::RST_CAL_REQ;
    end else begin
      cal_req_r <= cal_req_nxt;
    end
  end

  // Failed inputs stay requested but are not retried until asked again,
  // otherwise the routine would loop on a stuck input forever
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fail_r <= tcc_pkg::CH_NONE;
    end else begin
      fail_r <= (fail_r | ((done_w && !cal_ok) ? idx_mask : tcc_pkg::CH_NONE)) & ~new_req;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      analog_cal_failure_flag_r <= 1'b0;
    end else if (done_w && !cal_ok) begin
      analog_cal_failure_flag_r <= 1'b1;
    end else if (i_cal_fail_clr) begin
      analog_cal_failure_flag_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Calibration sequencer
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= tcc_pkg::CAL_IDLE;
      idx_r   <= tcc_pkg::IDX_FIRST;
      start_r <= 1'b0;
    end else begin
      start_r <= 1'b0;
      case (state_r)
        tcc_pkg::CAL_IDLE: begin
          idx_r <= tcc_pkg::IDX_FIRST;
          if (|pending) begin
            state_r <= tcc_pkg::CAL_SCAN;
          end
        end
        tcc_pkg::CAL_SCAN: begin
          if (pending[idx_r]) begin
            state_r <= tcc_pkg::CAL_WAIT;
            start_r <= 1'b1;
          end else if (idx_r == tcc_pkg::IDX_LAST) begin
            state_r <= tcc_pkg::CAL_IDLE;
          end else begin
            idx_r <= idx_r + tcc_pkg::IDX_ONE;
          end
        end
        tcc_pkg::CAL_WAIT: begin
          if (i_cal_rsp.done) begin
            if (idx_r == tcc_pkg::IDX_LAST) begin
              state_r <= tcc_pkg::CAL_IDLE;
            end else begin
              state_r <= tcc_pkg::CAL_SCAN;
              idx_r   <= idx_r + tcc_pkg::IDX_ONE;
            end
          end
        end
        default: begin
          state_r <= tcc_pkg::CAL_IDLE;
        end
      endcase
    end
  end

  assign o_cal_start = start_r;
  assign o_cal_chan  = idx_r;

  // ------------------------------------------------------------
  // Per-input storage and event generators
  // ------------------------------------------------------------
  tcc_step_div #(
    .STEP_CYCLES (STEP_CYCLES)
  ) u_step (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .o_tick  (step_tick)
  );

  for (genvar g = 0; g < tcc_pkg::NUM_IN; g++) begin : g_in
    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        cal_val_r[g] <= tcc_pkg::CAL_RST;
      end else if (done_w && idx_r == 3'(g)) begin
        cal_val_r[g] <= i_cal_rsp.value;
      end
    end

    tcc_chan_evt u_evt (
      .i_clk       (i_clk),
      .i_rst_n     (i_rst_n),
      .i_tick      (step_tick),
      .i_touch     (i_touch[g]),
      .i_rpt_en    (rpt_en_r[g]),
      .i_rel_en    (i_release_irq_enable),
      .i_min_press (i_min_press),
      .i_interval  (i_repeat_interval),
      .o_event     (evt[g]),
      .o_hold      ()
    );
  end

  assign o_channel_cal_value = cal_val_r;

  // ------------------------------------------------------------
  // Enable registers and alert
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_en_r <= tcc_pkg::RST_IRQ_EN;
    end else if (wr_irq) begin
      irq_en_r <= i_reg.wdata[tcc_pkg::NUM_IN-1:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rpt_en_r <= tcc_pkg::RST_RPT_EN;
    end else if (wr_rpt) begin
      rpt_en_r <= i_reg.wdata[tcc_pkg::NUM_IN-1:0];
    end
  end

  assign gated_evt = evt & irq_en_r;

  // A new event in the clearing cycle keeps the alert asserted
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      alert_r <= 1'b0;
    end else if (|gated_evt) begin
      alert_r <= 1'b1;
    end else if (i_alert_clr) begin
      alert_r <= 1'b0;
    end
  end

  assign o_alert_n                 = ~alert_r;
  assign o_chan_event              = gated_evt;
  assign o_analog_cal_failure_flag = analog_cal_failure_flag_r;

  // ------------------------------------------------------------
  // Register read
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_r <= '0;
    end else if (i_reg.rd) begin
      case (i_reg.addr)
        tcc_pkg::ADDR_CAL_REQ: rdata_r <= {tcc_pkg::UNUSED_BITS, cal_req_r};
        tcc_pkg::ADDR_IRQ_EN:  rdata_r <= {tcc_pkg::UNUSED_BITS, irq_en_r};
        tcc_pkg::ADDR_RPT_EN:  rdata_r <= {tcc_pkg::UNUSED_BITS, rpt_en_r};
        default:               rdata_r <= '0;
      endcase
    end
  end

  assign o_reg_rdata = rdata_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_cal_clear;
    @(posedge i_clk) disable iff (!i_rst_n)
    (cal_ok && !wr_cal && !(|(i_newly_enabled & idx_mask))) |=> !cal_req_r[$past(idx_r)];
  endproperty
  a_cal_clear: assert property (p_cal_clear) else $error("good calibration left bit set");

  property p_cal_keep;
    @(posedge i_clk) disable iff (!i_rst_n)
    (done_w && !cal_ok && cal_req_r[idx_r] && !wr_cal) |=> cal_req_r[$past(idx_r)];
  endproperty
  a_cal_keep: assert property (p_cal_keep) else $error("failed calibration cleared bit");

  property p_fail_flag;
    @(posedge i_clk) disable iff (!i_rst_n)
    (done_w && !cal_ok) |=> o_analog_cal_failure_flag;
  endproperty
  a_fail_flag: assert property (p_fail_flag) else $error("failure flag not raised");

  property p_newly_set;
    @(posedge i_clk) disable iff (!i_rst_n)
    (|i_newly_enabled) |=> ((cal_req_r & $past(i_newly_enabled)) == $past(i_newly_enabled));
  endproperty
  a_newly_set: assert property (p_newly_set) else $error("newly enabled input not requested");

  property p_cal_value;
    @(posedge i_clk) disable iff (!i_rst_n)
    done_w |=> (o_channel_cal_value[$past(idx_r)] == $past(i_cal_rsp.value));
  endproperty
  a_cal_value: assert property (p_cal_value) else $error("calibration value not stored");

  property p_skip;
    @(posedge i_clk) disable iff (!i_rst_n)
    (state_r == tcc_pkg::CAL_SCAN && !pending[idx_r])
      |=> !o_cal_start ##1 !(o_cal_start && o_cal_chan == $past(idx_r, 2));
  endproperty
  a_skip: assert property (p_skip) else $error("cancelled input was calibrated");

  property p_alert_on;
    @(posedge i_clk) disable iff (!i_rst_n)
    (|(evt & irq_en_r)) |=> !o_alert_n;
  endproperty
  a_alert_on: assert property (p_alert_on) else $error("enabled event missed alert");

  property p_alert_gate;
    @(posedge i_clk) disable iff (!i_rst_n)
    (o_alert_n && !(|(evt & irq_en_r))) |=> o_alert_n;
  endproperty
  a_alert_gate: assert property (p_alert_gate) else $error("masked event asserted alert");

  property p_unused_zero;
    @(posedge i_clk) disable iff (!i_rst_n)
    i_reg.rd |=> (o_reg_rdata[7:6] == tcc_pkg::UNUSED_BITS);
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bits read nonzero");

  property p_cal_launch;
    @(posedge i_clk) disable iff (!i_rst_n)
    (state_r == tcc_pkg::CAL_SCAN && pending[idx_r]) |=> (o_cal_start && o_cal_chan == $past(idx_r));
  endproperty
  a_cal_launch: assert property (p_cal_launch) else $error("pending input not started");

  property p_fail_sticky;
    @(posedge i_clk) disable iff (!i_rst_n)
    (o_analog_cal_failure_flag && !i_cal_fail_clr) |=> o_analog_cal_failure_flag;
  endproperty
  a_fail_sticky: assert property (p_fail_sticky) else $error("failure flag dropped on its own");

  property p_irq_write;
    @(posedge i_clk) disable iff (!i_rst_n)
    wr_irq |=> (irq_en_r == $past(i_reg.wdata[tcc_pkg::NUM_IN-1:0]));
  endproperty
  a_irq_write: assert property (p_irq_write) else $error("interrupt enable write lost");

  property p_rpt_write;
    @(posedge i_clk) disable iff (!i_rst_n)
    wr_rpt |=> (rpt_en_r == $past(i_reg.wdata[tcc_pkg::NUM_IN-1:0]));
  endproperty
  a_rpt_write: assert property (p_rpt_write) else $error("repeat enable write lost");

endmodule

/* dv/tcc_cal_model.sv */
// Behavioural analog calibration engine that answers the block's start pulses
`timescale 1ns/1ps
module tcc_cal_model (
  input  wire logic                      i_clk,
  input  wire logic                      i_rst_n,
  input  wire logic                      i_start,
  input  wire logic [3:0]                i_delay,
  input  wire logic [tcc_pkg::CAL_W-1:0] i_value,
  output tcc_pkg::tcc_cal_rsp_t          o_rsp
);
  int cnt;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt <= 0;
      o_rsp <= '0;
    end else begin
      o_rsp.done <= 1'b0;
      // Value wanders outside a result so a stale read cannot pass
      o_rsp.value <= ~o_rsp.value;
      if (i_start) begin
        cnt <= (i_delay == 4'h0) ? 1 : int'(i_delay);
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end else if (cnt == 1) begin
        cnt <= 0;
        o_rsp <= {1'b1, i_value};
      end
    end
  end
endmodule

/* dv/tb_top.sv */
// Self-checking bench for the touch channel control block
`timescale 1ns/1ps
module tb_top;
  logic                  clk = 1'b0;
  logic                  rst_n = 1'b0;
  tcc_pkg::tcc_reg_req_t req;
  tcc_pkg::tcc_cal_rsp_t rsp;
  logic [7:0]            rdata;
  logic [5:0]            touch, noise, newen, ev, evs, en;
  logic                  rel_en, start, flag, alert_n, fclr, aclr;
  logic [3:0]            mpress, rint, dly;
  logic [2:0]            chan;
  logic [5:0][9:0]       calv;
  logic [9:0]            mval;
  logic [7:0]            seed = 8'h4d;
  int                    bad_count = 0, compares = 0, cyc = 0, st = 0, k;
  int                    evq[$];
  always #12.5 clk = ~clk;
  tcc_top #(.STEP_CYCLES(20)) u_tcc_top (.i_clk(clk), .i_rst_n(rst_n), .i_reg(req), .o_reg_rdata(rdata),
    .i_touch(touch), .i_noise(noise), .i_newly_enabled(newen), .i_release_irq_enable(rel_en),
    .i_min_press(mpress), .i_repeat_interval(rint), .o_cal_start(start), .o_cal_chan(chan),
    .i_cal_rsp(rsp), .o_channel_cal_value(calv), .o_analog_cal_failure_flag(flag),
    .i_cal_fail_clr(fclr), .o_alert_n(alert_n), .i_alert_clr(aclr), .o_chan_event(ev));
  tcc_cal_model u_tcc_cal_model (.i_clk(clk), .i_rst_n(rst_n), .i_start(start), .i_delay(dly),
    .i_value(mval), .o_rsp(rsp));
  // ----
  // Helpers
  // ----
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (bad_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Bus tasks start just after a falling edge and leave one idle cycle behind
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge clk) req = '0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge clk) req = '0;
    chk(16'(rdata), 16'(exp));
    @(negedge clk);
  endtask
  task automatic watch(input int n);
    repeat (n) begin
      @(negedge clk);
      if (ev != 6'h00) evq.push_back(cyc);
      evs |= ev;
      if (start) st++;
    end
  endtask
  task automatic cal(input logic [2:0] exp);
    int i;
    for (i = 0; i < 100 && start !== 1'b1; i++) @(negedge clk);
    chk(16'(start), 16'h1);
    chk(16'(chan), 16'(exp));
    repeat (14) @(negedge clk);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end
  // ----
  // Main sequence
  // ----
  initial begin
    req = '0; touch = 6'h00; noise = 6'h00; newen = 6'h00; rel_en = 1'b0; fclr = 1'b0; aclr = 1'b0;
    mpress = 4'h0; rint = 4'h1; dly = 4'h1; mval = 10'h123; evs = 6'h00;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    rd(8'h26, 8'h00);
    rd(8'h27, 8'h3f);
    rd(8'h28, 8'h3f);
    rd(8'h29, 8'h00);
    wr(8'h27, 8'hff);
    rd(8'h27, 8'h3f);
    wr(8'h26, 8'h04);
    cal(3'h2);
    rd(8'h26, 8'h00);
    chk(16'(calv[2]), 16'h0123);
    chk(16'(flag), 16'h0);
    dly = 4'h9; mval = 10'h3ff;
    wr(8'h26, 8'h01);
    cal(3'h0);
    rd(8'h26, 8'h01);
    chk(16'(flag), 16'h1);
    fclr = 1'b1;
    @(negedge clk) fclr = 1'b0;
    chk(16'(flag), 16'h0);
    noise = 6'h02; mval = 10'h155;
    wr(8'h26, 8'h02);
    cal(3'h1);
    rd(8'h26, 8'h02);
    chk(16'(flag), 16'h1);
    noise = 6'h00; mval = 10'h2a5; dly = 4'h1;
    wr(8'h26, 8'h00);
    newen = 6'h10;
    @(negedge clk) newen = 6'h00;
    cal(3'h4);
    chk(16'(calv[4]), 16'h02a5);
    wr(8'h26, 8'h20);
    wr(8'h26, 8'h00);
    st = 0;
    watch(20);
    chk(16'(st), 16'h0);
    // Touch and release gating with random enables, repeat off
    wr(8'h28, 8'h00);
    for (k = 0; k < 6; k++) begin
      seed = lfsr(seed); en = seed[5:0]; rel_en = seed[7];
      // Odd inputs are masked so the gating path really sees a disabled input
      en[k] = ~k[0];
      wr(8'h27, {2'h0, en});
      aclr = 1'b1;
      @(negedge clk) aclr = 1'b0;
      evs = 6'h00; touch[k] = 1'b1;
      watch(4);
      chk(16'(evs), 16'(en & (6'h01 << k)));
      chk(16'(alert_n), 16'(!en[k]));
      aclr = 1'b1;
      @(negedge clk) aclr = 1'b0;
      evs = 6'h00; touch[k] = 1'b0;
      watch(4);
      chk(16'(evs), 16'({5'h00, en[k] & rel_en} << k));
      chk(16'(alert_n), 16'(!(en[k] & rel_en)));
    end
    wr(8'h27, 8'h3f);
    rel_en = 1'b0; evq.delete(); touch[0] = 1'b1;
    watch(200);
    chk(16'(evq.size()), 16'h1);
    touch[0] = 1'b0;
    watch(5);
    wr(8'h28, 8'h01);
    evq.delete(); touch[0] = 1'b1;
    watch(300);
    touch[0] = 1'b0;
    watch(4);
    chk(16'(evq.size() >= 4), 16'h1);
    if (evq.size() >= 4) begin
      chk(16'((evq[1] - evq[0]) inside {[55:85]}), 16'h1);
      chk(16'(evq[2] - evq[1]), 16'd40);
      chk(16'(evq[3] - evq[2]), 16'd40);
    end
    rel_en = 1'b1; evq.delete(); touch[0] = 1'b1;
    watch(5);
    touch[0] = 1'b0;
    watch(60);
    chk(16'(evq.size()), 16'h2);
    summarize();
  end
endmodule
